/* File: verilog/spfcc_pkg.sv */
// Shared constants, register map and types of the serial packet framer.
package spfcc_pkg;

	// ==========================================================
	// Sizes and timing
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_CONN = 4;
	localparam int BUF_DEPTH = 1024;
	localparam int MS_W = 16;
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_DELIM = 8'h04;
	localparam logic [ADDR_W-1:0] REG_GAP = 8'h08;
	localparam logic [ADDR_W-1:0] REG_INACT = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_DEST = 8'h10;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h14;
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] REG_LPORT0 = 8'h20;
	localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

	// ==========================================================
	// Field positions
	localparam int CTRL_W = 19;
	localparam int CTRL_MAXLEN_LSB = 0;
	localparam int CTRL_MAXLEN_W = 11;
	localparam int CTRL_D1EN_BIT = 11;
	localparam int CTRL_D2EN_BIT = 12;
	localparam int CTRL_PROC_LSB = 13;
	localparam int CTRL_SKIP_BIT = 15;
	localparam int CTRL_POL_LSB = 16;
	localparam int DELIM_D1_LSB = 0;
	localparam int DELIM_D2_LSB = 8;
	localparam int CMD_CLOSE_BIT = 0;
	localparam int STAT_OPEN_BIT = 0;
	localparam int STAT_JAM_LSB = 1;
	localparam int STAT_HOLD_BIT = 5;
	localparam int STAT_CNT_LSB = 16;

	// ==========================================================
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 19'h00000;
	localparam logic [15:0] DELIM_RST = 16'h0000;
	localparam logic [MS_W-1:0] GAP_RST = 16'h0000;
	localparam logic [MS_W-1:0] INACT_RST = 16'h0000;
	localparam logic [NUM_CONN-1:0] DEST_RST = 4'h1;
	localparam logic [15:0] LPORT_RST = 16'h0001;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {PROC_NONE, PROC_PLUS1, PROC_PLUS2, PROC_STRIP} spfcc_proc_t;
	typedef enum logic [2:0] {
		POL_STARTUP, POL_ANY_NONE, POL_ANY_INACT, POL_DSR_FOLLOW,
		POL_DSR_NONE, POL_DCD_FOLLOW, POL_DCD_NONE
	} spfcc_pol_t;

endpackage

/* File: verilog/spfcc_tmr_if.sv */
// Interface between the framer and one millisecond timeout timer.
`timescale 1ns/100ps
interface spfcc_tmr_if;
	logic restart;
	logic [15:0] limit;
	logic expired;
	modport ctl (output restart, output limit, input expired);
	modport tmr (input restart, input limit, output expired);
endinterface

/* File: verilog/spfcc_ms_timer.sv */
// Millisecond timeout timer: one expiry pulse after limit ms without restart.
`timescale 1ns/100ps
module spfcc_ms_timer
	import spfcc_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst,
	spfcc_tmr_if.tmr tif
);
	localparam int PRE_W = $clog2(CYC_MS);

	logic [PRE_W-1:0] pre_ff, nxt_pre;
	logic [MS_W-1:0] ms_ff, nxt_ms;
	logic done_ff, nxt_done;
	logic expired_ff, nxt_expired;

	// A limit of zero never expires, so the wait is indefinite.
	always_comb begin
		nxt_pre = pre_ff;
		nxt_ms = ms_ff;
		nxt_done = done_ff;
		nxt_expired = 1'b0;
		if (tif.restart) begin
			nxt_pre = '0;
			nxt_ms = '0;
			nxt_done = 1'b0;
		end else if (!done_ff && tif.limit != '0) begin
			nxt_pre = pre_ff + 1'b1;
			if (pre_ff == PRE_W'(CYC_MS - 1)) begin
				nxt_pre = '0;
				nxt_ms = ms_ff + 1'b1;
				if (nxt_ms == tif.limit) begin
					nxt_done = 1'b1;
					nxt_expired = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_ff <= '0;
			ms_ff <= '0;
			done_ff <= 1'b0;
			expired_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			ms_ff <= nxt_ms;
			done_ff <= nxt_done;
			expired_ff <= nxt_expired;
		end
	end

	assign tif.expired = expired_ff;
endmodule // spfcc_ms_timer

/* File: verilog/spfcc_framer.sv */
// Serial packet framer with connection control for up to four client links.
// ==========================================================
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
module spfcc_framer
	import spfcc_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic netActive,
	input wire logic dsr,
	input wire logic dcd,
	input wire logic [NUM_CONN-1:0] hostResp,
	output logic outValid,
	output logic [7:0] outData,
	output logic outPack,
	output logic [NUM_CONN-1:0] connUp,
	output logic [NUM_CONN-1:0] txGo,
	output logic [NUM_CONN-1:0] hostJam,
	output logic [16*NUM_CONN-1:0] localPorts
);
	localparam int CNT_W = $clog2(DEPTH + 1);

	// ==========================================================
	// Register file
	logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [15:0] delim_ff, nxt_delim;
	logic [MS_W-1:0] gap_ff, nxt_gap, inact_ff, nxt_inact;
	logic [NUM_CONN-1:0] dest_ff, nxt_dest;
	logic [15:0] lport_ff [NUM_CONN], nxt_lport [NUM_CONN];
	logic closeCmd_ff, nxt_closeCmd;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic open_ff, nxt_open;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [NUM_CONN-1:0] jam_ff, nxt_jam;

	logic [CTRL_MAXLEN_W-1:0] maxLen;
	logic d1En, d2En, skipJam;
	spfcc_proc_t proc;
	spfcc_pol_t pol;
	assign maxLen = ctrl_ff[CTRL_MAXLEN_LSB +: CTRL_MAXLEN_W];
	assign d1En = ctrl_ff[CTRL_D1EN_BIT];
	assign d2En = ctrl_ff[CTRL_D2EN_BIT];
	assign skipJam = ctrl_ff[CTRL_SKIP_BIT];
	assign proc = spfcc_proc_t'(ctrl_ff[CTRL_PROC_LSB +: 2]);
	assign pol = spfcc_pol_t'(ctrl_ff[CTRL_POL_LSB +: 3]);

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_delim = delim_ff;
		nxt_gap = gap_ff;
		nxt_inact = inact_ff;
		nxt_dest = dest_ff;
		nxt_lport = lport_ff;
		nxt_closeCmd = 1'b0;
		nxt_rdata = '0;
		if (regWr) begin
			unique case (regAddr)
				REG_CTRL: nxt_ctrl = regWdata[CTRL_W-1:0];
				REG_DELIM: nxt_delim = regWdata[15:0];
				REG_GAP: nxt_gap = regWdata[MS_W-1:0];
				REG_INACT: nxt_inact = regWdata[MS_W-1:0];
				REG_DEST: begin
					// An empty destination set is refused so one link always remains.
					if (regWdata[NUM_CONN-1:0] != '0) begin
						nxt_dest = regWdata[NUM_CONN-1:0];
					end
				end
				REG_CMD: nxt_closeCmd = regWdata[CMD_CLOSE_BIT];
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CONN; i++) begin
				if (regAddr == REG_LPORT0 + ADDR_W'(i) * REG_STRIDE && regWdata[15:0] != '0) begin
					nxt_lport[i] = regWdata[15:0];
				end
			end
		end
		if (regRd) begin
			unique case (regAddr)
				REG_CTRL: nxt_rdata = DATA_W'(ctrl_ff);
				REG_DELIM: nxt_rdata = DATA_W'(delim_ff);
				REG_GAP: nxt_rdata = DATA_W'(gap_ff);
				REG_INACT: nxt_rdata = DATA_W'(inact_ff);
				REG_DEST: nxt_rdata = DATA_W'(dest_ff);
				REG_STAT: begin
					nxt_rdata[STAT_OPEN_BIT] = open_ff;
					nxt_rdata[STAT_JAM_LSB +: NUM_CONN] = jam_ff;
					nxt_rdata[STAT_HOLD_BIT] = !skipJam && (jam_ff != '0);
					nxt_rdata[STAT_CNT_LSB +: CNT_W] = cnt_ff;
				end
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CONN; i++) begin
				if (regAddr == REG_LPORT0 + ADDR_W'(i) * REG_STRIDE) begin
					nxt_rdata = DATA_W'(lport_ff[i]);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
			delim_ff <= DELIM_RST;
			gap_ff <= GAP_RST;
			inact_ff <= INACT_RST;
			dest_ff <= DEST_RST;
			for (int i = 0; i < NUM_CONN; i++) begin
				lport_ff[i] <= LPORT_RST;
			end
			closeCmd_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			delim_ff <= nxt_delim;
			gap_ff <= nxt_gap;
			inact_ff <= nxt_inact;
			dest_ff <= nxt_dest;
			lport_ff <= nxt_lport;
			closeCmd_ff <= nxt_closeCmd;
			rdata_ff <= nxt_rdata;
		end
	end
	assign regRdata = rdata_ff;

	// ==========================================================
	// Timers
	spfcc_tmr_if gapTif ();
	spfcc_tmr_if inactTif ();
	assign gapTif.restart = rxValid;
	assign gapTif.limit = gap_ff;
	assign inactTif.restart = rxValid || netActive;
	assign inactTif.limit = inact_ff;
	spfcc_ms_timer #(.CYC_MS(CYC_MS)) uGapTmr (.clk(clk), .rst(rst), .tif(gapTif));
	spfcc_ms_timer #(.CYC_MS(CYC_MS)) uInactTmr (.clk(clk), .rst(rst), .tif(inactTif));

	// ==========================================================
	// Packing path
	// One byte is held back so a trigger arriving later can still end the packet
	// on it, and so a held first delimiter can be dropped when the pair completes.
	logic pendV_ff, nxt_pendV, pendLast_ff, nxt_pendLast, prevD1_ff, nxt_prevD1;
	logic [7:0] pendD_ff, nxt_pendD, outData_ff, nxt_outData;
	logic [1:0] extra_ff, nxt_extra;
	logic outValid_ff, nxt_outValid, outPack_ff, nxt_outPack;
	logic isD1, matchSingle, matchDouble, delimHit, stripNow, lenHit, fullHit, trig;
	logic [CNT_W-1:0] cntBase, cntPlus;

	assign isD1 = rxValid && d1En && rxData == delim_ff[DELIM_D1_LSB +: 8];
	assign matchSingle = isD1 && !d2En;
	assign matchDouble = rxValid && d1En && d2En && prevD1_ff
		&& rxData == delim_ff[DELIM_D2_LSB +: 8];
	assign delimHit = matchSingle || matchDouble;
	assign stripNow = delimHit && proc == PROC_STRIP;

	always_comb begin
		nxt_pendV = pendV_ff;
		nxt_pendD = pendD_ff;
		nxt_pendLast = pendLast_ff;
		nxt_cnt = cnt_ff;
		nxt_extra = extra_ff;
		nxt_prevD1 = rxValid ? isD1 : prevD1_ff;
		nxt_outValid = 1'b0;
		nxt_outData = outData_ff;
		nxt_outPack = 1'b0;
		// A pending end mark or a gap expiry flushes the held byte first.
		if (pendV_ff && (pendLast_ff || gapTif.expired)) begin
			nxt_outValid = 1'b1;
			nxt_outData = pendD_ff;
			nxt_outPack = 1'b1;
			nxt_pendV = 1'b0;
			nxt_pendLast = 1'b0;
			nxt_cnt = '0;
		end
		cntBase = nxt_cnt;
		cntPlus = cntBase + 1'b1;
		lenHit = maxLen != '0 && cntPlus == CNT_W'(maxLen);
		fullHit = cntPlus == CNT_W'(DEPTH);
		trig = 1'b0;
		if (rxValid) begin
			if (delimHit && proc == PROC_PLUS1) begin
				nxt_extra = 2'h1;
			end else if (delimHit && proc == PROC_PLUS2) begin
				nxt_extra = 2'h2;
			end else if (extra_ff != '0) begin
				nxt_extra = extra_ff - 1'b1;
			end
			if (stripNow) begin
				// Held first delimiter of a pair is discarded, otherwise sent.
				if (nxt_pendV && !matchDouble) begin
					nxt_outValid = 1'b1;
					nxt_outData = pendD_ff;
				end
				nxt_pendV = 1'b0;
				nxt_pendLast = 1'b0;
				nxt_outPack = 1'b1;
				nxt_cnt = '0;
			end else begin
				if (nxt_pendV) begin
					nxt_outValid = 1'b1;
					nxt_outData = pendD_ff;
				end
				// Whichever trigger lands first ends the packet on this byte.
				trig = lenHit || fullHit || (delimHit && proc == PROC_NONE)
					|| extra_ff == 2'h1;
				nxt_pendV = 1'b1;
				nxt_pendD = rxData;
				nxt_pendLast = trig;
				nxt_cnt = cntPlus;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pendV_ff <= 1'b0;
			pendD_ff <= '0;
			pendLast_ff <= 1'b0;
			cnt_ff <= '0;
			extra_ff <= '0;
			prevD1_ff <= 1'b0;
			outValid_ff <= 1'b0;
			outData_ff <= '0;
			outPack_ff <= 1'b0;
		end else begin
			pendV_ff <= nxt_pendV;
			pendD_ff <= nxt_pendD;
			pendLast_ff <= nxt_pendLast;
			cnt_ff <= nxt_cnt;
			extra_ff <= nxt_extra;
			prevD1_ff <= nxt_prevD1;
			outValid_ff <= nxt_outValid;
			outData_ff <= nxt_outData;
			outPack_ff <= nxt_outPack;
		end
	end
	assign outValid = outValid_ff;
	assign outData = outData_ff;
	assign outPack = outPack_ff;

	// ==========================================================
	// Connection control
	logic started_ff, dsrPrev_ff, dcdPrev_ff;
	logic [NUM_CONN-1:0] connUp_ff, nxt_connUp, txGo_ff, nxt_txGo;
	logic dsrRise, dsrFall, dcdRise, dcdFall;
	assign dsrRise = dsr && !dsrPrev_ff;
	assign dsrFall = !dsr && dsrPrev_ff;
	assign dcdRise = dcd && !dcdPrev_ff;
	assign dcdFall = !dcd && dcdPrev_ff;

	always_comb begin
		nxt_open = open_ff;
		if (closeCmd_ff) begin
			nxt_open = 1'b0;
		end
		unique case (pol)
			POL_STARTUP: if (!started_ff) nxt_open = 1'b1;
			POL_ANY_NONE: if (rxValid) nxt_open = 1'b1;
			POL_ANY_INACT: begin
				if (inactTif.expired) nxt_open = 1'b0;
				if (rxValid) nxt_open = 1'b1;
			end
			POL_DSR_FOLLOW: begin
				if (dsrRise) nxt_open = 1'b1;
				if (dsrFall) nxt_open = 1'b0;
			end
			POL_DSR_NONE: if (dsrRise) nxt_open = 1'b1;
			POL_DCD_FOLLOW: begin
				if (dcdRise) nxt_open = 1'b1;
				if (dcdFall) nxt_open = 1'b0;
			end
			POL_DCD_NONE: if (dcdRise) nxt_open = 1'b1;
			default: nxt_open = open_ff;
		endcase
		nxt_connUp = {NUM_CONN{open_ff}} & dest_ff;
		nxt_jam = nxt_connUp & ~hostResp;
		// Without skipping, one stalled host holds every link until all answer.
		nxt_txGo = skipJam ? (nxt_connUp & hostResp)
			: ((nxt_jam != '0) ? '0 : nxt_connUp);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			open_ff <= 1'b0;
			started_ff <= 1'b0;
			dsrPrev_ff <= 1'b0;
			dcdPrev_ff <= 1'b0;
			connUp_ff <= '0;
			jam_ff <= '0;
			txGo_ff <= '0;
		end else begin
			open_ff <= nxt_open;
			started_ff <= 1'b1;
			dsrPrev_ff <= dsr;
			dcdPrev_ff <= dcd;
			connUp_ff <= nxt_connUp;
			jam_ff <= nxt_jam;
			txGo_ff <= nxt_txGo;
		end
	end
	assign connUp = connUp_ff;
	assign hostJam = jam_ff;
	assign txGo = txGo_ff;

	genvar g;
	generate
		for (g = 0; g < NUM_CONN; g++) begin : gPort
			assign localPorts[16*g +: 16] = lport_ff[g];
		end
	endgenerate

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_len;
		rxValid && !stripNow && !(pendV_ff && (pendLast_ff || gapTif.expired)) && lenHit
			|-> ##2 outPack_ff;
	endproperty
	a_len: assert property (p_len) else $error("length limit did not pack");
	property p_single;
		matchSingle && proc == PROC_NONE |-> ##2 outPack_ff && outData_ff == $past(rxData, 2);
	endproperty
	a_single: assert property (p_single) else $error("single delimiter did not pack");
	property p_strip;
		matchDouble && proc == PROC_STRIP |=> outPack_ff ##1 !outPack_ff || pendLast_ff;
	endproperty
	a_strip: assert property (p_strip) else $error("delimiter pair did not pack");
	property p_plus1;
		rxValid && extra_ff == 2'h1 && !stripNow |-> ##2 outPack_ff;
	endproperty
	a_plus1: assert property (p_plus1) else $error("delayed pack missed");
	property p_start;
		$fell(started_ff) or ($rose(started_ff) && pol == POL_STARTUP) |=> open_ff;
	endproperty
	a_start: assert property (p_start) else $error("startup open missed");
	property p_dsrClose;
		pol == POL_DSR_FOLLOW && dsrFall |=> !open_ff ##1 connUp_ff == '0;
	endproperty
	a_dsrClose: assert property (p_dsrClose) else $error("dsr fall did not close");
	property p_inact;
		pol == POL_ANY_INACT && inactTif.expired && !rxValid |=> !open_ff;
	endproperty
	a_inact: assert property (p_inact) else $error("inactivity did not close");
	// Expected link words are rebuilt from the open flag, the destination set and the raw host inputs.
	property p_hold;
		!skipJam && open_ff && (dest_ff & ~hostResp) != '0 |=> txGo_ff == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("stalled host did not halt");
	property p_skip;
		skipJam |=> txGo_ff
			== ({NUM_CONN{$past(open_ff)}} & $past(dest_ff) & $past(hostResp));
	endproperty
	a_skip: assert property (p_skip) else $error("responsive host stalled");
	property p_jam;
		##1 jam_ff == ({NUM_CONN{$past(open_ff)}} & $past(dest_ff) & ~$past(hostResp));
	endproperty
	a_jam: assert property (p_jam) else $error("jam flag wrong");

	c_len: cover property (lenHit ##2 outPack_ff);
	c_pair: cover property (matchDouble ##[1:2] outPack_ff);
	c_dsr: cover property (pol == POL_DSR_FOLLOW && dsrRise ##1 open_ff);
	c_hold: cover property (!skipJam && jam_ff != '0 && txGo_ff == '0);
endmodule // spfcc_framer

/* File: tb/spfcc_peer_model.sv */
// Model of the serial device, modem lines and remote hosts facing the framer.
`timescale 1ns/100ps
module spfcc_peer_model (
	input wire logic clk,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic netActive,
	output logic dsr,
	output logic dcd,
	output logic [3:0] hostResp
);
	// ==========================================================
	// Idle levels
	initial begin
		rxValid = 1'b0;
		rxData = 8'h5a;
		netActive = 1'b0;
		dsr = 1'b0;
		dcd = 1'b0;
		hostResp = 4'hf;
	end

	// ==========================================================
	// Stimulus tasks
	// The caller puts any delimiters into the byte list itself.
	// Bytes go on consecutive strobes; after the last one the lane shows its inverse, so stale data never looks valid.
	task automatic sendBytes(input logic [7:0] bs[$]);
		foreach (bs[i]) begin
			@(posedge clk);
			rxValid <= 1'b1;
			rxData <= bs[i];
		end
		@(posedge clk);
		rxValid <= 1'b0;
		rxData <= ~bs[bs.size()-1];
	endtask

	task automatic setModem(input logic d, input logic c);
		@(posedge clk);
		dsr <= d;
		dcd <= c;
	endtask

	task automatic setHosts(input logic [3:0] h);
		@(posedge clk);
		hostResp <= h;
	endtask

	task automatic netBurst(input int n);
		repeat (n) begin
			@(posedge clk);
			netActive <= 1'b1;
			@(posedge clk);
			netActive <= 1'b0;
		end
	endtask
endmodule // spfcc_peer_model

/* File: tb/tb_top.sv */
// Self-checking testbench of the serial packet framer.
`timescale 1ns/100ps
module tb_top
	import spfcc_pkg::*;
;
	// ==========================================================
	// Signals and instances
	// A short millisecond keeps every timeout scenario within a few dozen cycles.
	localparam int CMS = 4;
	logic clk, rst, regWr, regRd, rxValid, netActive, dsr, dcd, outValid, outPack;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata, regRdata;
	logic [7:0] rxData, outData;
	logic [NUM_CONN-1:0] hostResp, connUp, txGo, hostJam;
	logic [16*NUM_CONN-1:0] localPorts;
	logic [8:0] got[$];
	int errTotal = 0;
	int nChecks = 0;

	spfcc_framer #(.CYC_MS(CMS)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.rxValid(rxValid), .rxData(rxData), .netActive(netActive), .dsr(dsr), .dcd(dcd),
		.hostResp(hostResp), .outValid(outValid), .outData(outData), .outPack(outPack),
		.connUp(connUp), .txGo(txGo), .hostJam(hostJam), .localPorts(localPorts));
	spfcc_peer_model peer (.clk(clk), .rxValid(rxValid), .rxData(rxData),
		.netActive(netActive), .dsr(dsr), .dcd(dcd), .hostResp(hostResp));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Bytes leaving the framer, bit 8 set on the last byte of a packet.
	always @(posedge clk) begin
		if (outValid === 1'b1) begin
			got.push_back({outPack, outData});
		end else if (outPack === 1'b1 && got.size() > 0) begin
			got[got.size()-1][8] = 1'b1;
		end
	end

	// ==========================================================
	// Bus, compare and wait tasks
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdata;
	endtask

	function automatic logic [DATA_W-1:0] ctl(input logic [10:0] len, input logic d1,
		input logic d2, input logic [1:0] pr, input logic sk, input logic [2:0] pol);
		return {13'h0, pol, sk, pr, d2, d1, len};
	endfunction

	task automatic printVerdict();
		$display("Checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		nChecks++;
		if (g !== e) begin
			errTotal++;
			$display("ERROR %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask

	task automatic chkStream(input logic [8:0] exp[$]);
		chk(32'(got.size()), 32'(exp.size()), "stream length");
		foreach (exp[i]) begin
			if (i < got.size()) begin
				chk({23'h0, got[i]}, {23'h0, exp[i]}, "stream byte");
			end
		end
	endtask

	task automatic waitUp(input logic [3:0] e, input int bound);
		int n;
		n = 0;
		while (connUp !== e && n < bound) begin
			@(posedge clk);
			n++;
		end
		chk({28'h0, connUp}, {28'h0, e}, "link state");
		if (connUp !== e) begin
			printVerdict();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic scReset();
		logic [31:0] d;
		chk(localPorts[31:0], 32'h0001_0001, "port reset");
		chk({26'h0, outValid, outPack, connUp}, 32'h0, "outputs at reset");
		waitUp(4'h1, 6);
		rd(REG_CTRL, d);
		chk(d, 32'h0, "ctrl reset");
		rd(8'h40, d);
		chk(d, 32'h0, "unmapped read");
		wr(REG_DEST, 32'h0);
		rd(REG_DEST, d);
		chk(d, 32'h1, "dest zero refused");
		wr(REG_LPORT0 + REG_STRIDE, 32'h1234);
		wr(REG_LPORT0 + 8'h0c, 32'h0);
		repeat (2) @(posedge clk);
		chk(localPorts[47:16], 32'h0001_1234, "port write");
		chk({16'h0, localPorts[63:48]}, 32'h1, "port zero refused");
	endtask

	task automatic scLen();
		wr(REG_CTRL, ctl(11'h2, 1'b0, 1'b0, PROC_NONE, 1'b0, POL_STARTUP));
		got.delete();
		peer.sendBytes('{8'h41, 8'h42, 8'h43, 8'h44});
		repeat (10) @(posedge clk);
		chkStream('{9'h041, 9'h142, 9'h043, 9'h144});
		wr(REG_CTRL, ctl(11'h1, 1'b0, 1'b0, PROC_NONE, 1'b0, POL_STARTUP));
		got.delete();
		peer.sendBytes('{8'h41, 8'h42});
		repeat (10) @(posedge clk);
		chkStream('{9'h141, 9'h142});
	endtask

	task automatic scGap();
		wr(REG_CTRL, 32'h0);
		got.delete();
		peer.sendBytes('{8'h41, 8'h42, 8'h43});
		repeat (20) @(posedge clk);
		chkStream('{9'h041, 9'h042});
		wr(REG_GAP, 32'h1);
		repeat (30) @(posedge clk);
		chkStream('{9'h041, 9'h042, 9'h143});
	endtask

	task automatic dcase(input logic [31:0] c, input logic [7:0] bs[$], input logic [8:0] e[$]);
		wr(REG_CTRL, c);
		got.delete();
		peer.sendBytes(bs);
		repeat (30) @(posedge clk);
		chkStream(e);
	endtask

	task automatic scDelim();
		wr(REG_DELIM, 32'h0000_0a0d);
		dcase(ctl(11'h0, 1'b1, 1'b0, PROC_NONE, 1'b0, POL_STARTUP), '{8'h41, 8'h0d, 8'h42},
			'{9'h041, 9'h10d, 9'h142});
		dcase(ctl(11'h0, 1'b1, 1'b0, PROC_PLUS1, 1'b0, POL_STARTUP),
			'{8'h41, 8'h0d, 8'h42, 8'h43}, '{9'h041, 9'h00d, 9'h142, 9'h143});
		dcase(ctl(11'h0, 1'b1, 1'b0, PROC_PLUS2, 1'b0, POL_STARTUP),
			'{8'h41, 8'h0d, 8'h42, 8'h43, 8'h44},
			'{9'h041, 9'h00d, 9'h042, 9'h143, 9'h144});
		dcase(ctl(11'h0, 1'b1, 1'b0, PROC_STRIP, 1'b0, POL_STARTUP), '{8'h41, 8'h0d, 8'h42},
			'{9'h141, 9'h142});
		dcase(ctl(11'h0, 1'b1, 1'b1, PROC_NONE, 1'b0, POL_STARTUP),
			'{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a},
			'{9'h041, 9'h00d, 9'h042, 9'h00d, 9'h10a});
		dcase(ctl(11'h0, 1'b1, 1'b1, PROC_STRIP, 1'b0, POL_STARTUP),
			'{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a}, '{9'h041, 9'h00d, 9'h142});
		dcase(ctl(11'h0, 1'b0, 1'b0, PROC_STRIP, 1'b0, POL_STARTUP), '{8'h41, 8'h0d},
			'{9'h041, 9'h10d});
		wr(REG_DELIM, 32'h0000_00ff);
		dcase(ctl(11'h0, 1'b1, 1'b1, PROC_NONE, 1'b0, POL_STARTUP), '{8'h00, 8'hff, 8'h00},
			'{9'h000, 9'h0ff, 9'h100});
	endtask

	task automatic connCase(input logic [2:0] pol);
		wr(REG_CTRL, ctl(11'h0, 1'b0, 1'b0, PROC_NONE, 1'b0, pol));
		wr(REG_CMD, 32'h1);
		waitUp(4'h0, 8);
		if (pol == POL_STARTUP) begin
			repeat (12) @(posedge clk);
			chk({28'h0, connUp}, 32'h0, "startup reopened");
			return;
		end
		if (pol == POL_DSR_FOLLOW || pol == POL_DSR_NONE) begin
			peer.setModem(1'b1, 1'b0);
		end else if (pol == POL_DCD_FOLLOW || pol == POL_DCD_NONE) begin
			peer.setModem(1'b0, 1'b1);
		end else begin
			peer.sendBytes('{8'h55});
		end
		waitUp(4'h1, 8);
		if (pol == POL_ANY_INACT) begin
			peer.netBurst(8);
			chk({28'h0, connUp}, 32'h1, "held open by traffic");
			waitUp(4'h0, 40);
		end else if (pol == POL_DSR_FOLLOW || pol == POL_DCD_FOLLOW) begin
			peer.setModem(1'b0, 1'b0);
			waitUp(4'h0, 8);
		end else begin
			peer.setModem(1'b0, 1'b0);
			repeat (12) @(posedge clk);
			chk({28'h0, connUp}, 32'h1, "manual policy held");
			wr(REG_CMD, 32'h1);
			waitUp(4'h0, 8);
		end
	endtask

	task automatic scHost();
		logic [31:0] d;
		wr(REG_DEST, 32'hf);
		wr(REG_CTRL, ctl(11'h0, 1'b0, 1'b0, PROC_NONE, 1'b0, POL_ANY_NONE));
		peer.sendBytes('{8'h55});
		waitUp(4'hf, 8);
		chk({28'h0, txGo}, 32'hf, "all hosts go");
		peer.setHosts(4'b1011);
		repeat (3) @(posedge clk);
		chk({28'h0, hostJam}, 32'h4, "jam flag");
		chk({28'h0, txGo}, 32'h0, "halt all");
		rd(REG_STAT, d);
		chk(d, 32'h0000_0029, "status word");
		wr(REG_CTRL, ctl(11'h0, 1'b0, 1'b0, PROC_NONE, 1'b1, POL_ANY_NONE));
		repeat (3) @(posedge clk);
		chk({28'h0, txGo}, 32'hb, "skip jammed");
		wr(REG_CTRL, ctl(11'h0, 1'b0, 1'b0, PROC_NONE, 1'b0, POL_ANY_NONE));
		peer.setHosts(4'hf);
		repeat (3) @(posedge clk);
		chk({28'h0, txGo}, 32'hf, "resume");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		scReset();
		scLen();
		scGap();
		scDelim();
		wr(REG_INACT, 32'h1);
		for (int p = 0; p < 7; p++) begin
			connCase(3'(p));
		end
		scHost();
		printVerdict();
	end
endmodule // tb_top
